/* design/cp0_pkg.sv */
// Constants shared by the system coprocessor timer and status logic
package coproc_pkg;
  // Coprocessor register numbers and selects
  localparam logic [4:0]  REG_COUNT      = 5'h09;
  localparam logic [4:0]  REG_MATCH      = 5'h0B;
  localparam logic [4:0]  REG_STATUS     = 5'h0C;
  localparam logic [2:0]  SEL_PRIMARY    = 3'h0;
  // Status field positions
  localparam int          COP_USABLE_BIT = 28;
  localparam int          BOOT_VEC_BIT   = 22;
  localparam int          SHUTDOWN_BIT   = 21;
  localparam int          SOFT_RESET_BIT = 20;
  localparam int          THR_B7_BIT     = 18;
  localparam int          THR_B6_BIT     = 16;
  localparam int          THR_LO_HI      = 15;
  localparam int          THR_LO_LO      = 10;
  localparam int          USER_SEL_BIT   = 4;
  localparam int          ERR_LVL_BIT    = 2;
  localparam int          EXC_LVL_BIT    = 1;
  localparam int          IRQ_EN_BIT     = 0;
  // Plain read/write bits; flag bits with own rules and unimplemented bits excluded
  localparam logic [31:0] STATUS_WMASK = 32'h1B4DFC17;
  // Status after reset: boot vectors, soft reset flag, error level
  localparam logic [31:0] STATUS_RESET = 32'h00500004;
  localparam logic [31:0] MATCH_RESET  = 32'h00000000;
  localparam logic [31:0] COUNT_RESET  = 32'h00000000;
  // Tick counter advances once per this many core clocks
  localparam int          TICK_DIV     = 2;
endpackage

/* design/tick_if.sv */
// Link between the status logic and the free-running tick counter
`timescale 1ns/100ps
interface tick_if;
  logic [31:0] count;     // Current tick count
  logic        wr;        // Load strobe for the count
  logic [31:0] wdata;     // Value loaded on wr
  logic        disable_c; // Counting stopped while high

  modport ctrl (output wr, output wdata, output disable_c, input count);
  modport counter (input wr, input wdata, input disable_c, output count);
endinterface

/* design/tick_counter.sv */
// Free-running tick counter advancing every other core clock
`timescale 1ns/100ps
module tick_counter (
  input  wire logic clock_i,   // Core clock
  input  wire logic reset_n_i, // Async reset, active low
  tick_if.counter   tk         // Count link
);
  logic        div_ff;   // Half-rate phase
  logic [31:0] count_ff; // Tick count

  // Phase toggles only while counting, so a pause keeps the rhythm
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_ff <= 1'b0;
    end else if (!tk.disable_c) begin
      div_ff <= ~div_ff;
    end
  end

  // Software load wins over the tick in the same cycle
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_ff <= coproc_pkg::COUNT_RESET;
    end else if (tk.wr) begin
      count_ff <= tk.wdata;
    end else if (!tk.disable_c && div_ff) begin
      count_ff <= count_ff + 32'h00000001;
    end
  end

  assign tk.count = count_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence run_two_s;
    (!tk.disable_c && !tk.wr)[*2];
  endsequence

  tick_rate_a: assert property (run_two_s |=> count_ff == $past(count_ff, 2) + 32'h00000001)
    else $error("tick count did not advance once per two clocks");
  tick_pause_a: assert property (tk.disable_c && !tk.wr |=> $stable(count_ff))
    else $error("tick count moved while disabled");
endmodule

/* design/cp0_timer_status.sv */
// System coprocessor match timer, status register, mode and access decode
`timescale 1ns/100ps
module coproc_timer_status (
  input  wire logic        clock_i,          // Core clock, 10 MHz
  input  wire logic        reset_n_i,        // Async reset, active low
  input  wire logic        cop_wr_i,         // Move-to-coprocessor strobe
  input  wire logic        cop_rd_i,         // Move-from-coprocessor strobe
  input  wire logic [4:0]  cop_reg_i,        // Register number
  input  wire logic [2:0]  cop_sel_i,        // Register select
  input  wire logic [31:0] cop_wdata_i,      // Write data
  output logic      [31:0] cop_rdata_o,      // Read data, valid after cop_rd_i
  output logic             cop_unusable_o,   // Access refused, raise exception
  input  wire logic        debug_mode_flag_i,// Debug mode indication
  input  wire logic        count_disable_i,  // Stops the tick counter
  input  wire logic        tlb_shutdown_set_i,// Hardware TLB shutdown event
  input  wire logic        irq_req_i,        // Pending interrupt request
  input  wire logic [7:0]  irq_level_i,      // Priority of that request
  output logic             irq_take_o,       // Request may be taken
  output logic             irq_enabled_o,    // Global enable condition holds
  output logic             timer_irq_o,      // Timer interrupt to controller
  output logic             user_mode_o,      // Core in user mode
  output logic             kernel_mode_o,    // Core in kernel mode
  output logic             debug_mode_o,     // Core in debug mode
  output logic             boot_vector_select_o // Bootstrap exception vectors
);
  tick_if tk ();

  logic [31:0] match_ff;     // Timer match value
  logic [31:0] status_ff;    // Processor mode status
  logic [31:0] rdata_ff;     // Read data holding register
  logic        irq_ff;       // Timer interrupt latch
  logic        eq_prev_ff;   // Equality seen last cycle
  logic        eq_now;       // Count equals match
  logic        hit;          // Count became equal to match
  logic        cop_allowed;  // Coprocessor access permitted
  logic        wr_ok;        // Permitted write
  logic        sel_ok;       // Primary select
  logic        wr_match;     // Write to match value
  logic        wr_status;    // Write to status
  logic        wr_count;     // Write to tick count
  logic        global_irq_enable;
  logic        exception_level;
  logic        error_level;
  logic        user_mode_select;
  logic        sys_copro_usable;
  logic        tlb_shutdown_flag;
  logic        soft_reset_flag;
  logic [7:0]  priority_threshold;

  tick_counter u_tick (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .tk        (tk.counter)
  );

  // Status field views
  assign global_irq_enable  = status_ff[coproc_pkg::IRQ_EN_BIT];
  assign exception_level    = status_ff[coproc_pkg::EXC_LVL_BIT];
  assign error_level        = status_ff[coproc_pkg::ERR_LVL_BIT];
  assign user_mode_select   = status_ff[coproc_pkg::USER_SEL_BIT];
  assign sys_copro_usable   = status_ff[coproc_pkg::COP_USABLE_BIT];
  assign tlb_shutdown_flag  = status_ff[coproc_pkg::SHUTDOWN_BIT];
  assign soft_reset_flag    = status_ff[coproc_pkg::SOFT_RESET_BIT];
  assign priority_threshold = {status_ff[coproc_pkg::THR_B7_BIT],
                               status_ff[coproc_pkg::THR_B6_BIT],
                               status_ff[coproc_pkg::THR_LO_HI:coproc_pkg::THR_LO_LO]};

  // Mode decode; debug overrides the status mode bits
  assign debug_mode_o  = debug_mode_flag_i;
  assign user_mode_o   = !debug_mode_flag_i && user_mode_select
                         && !exception_level && !error_level;
  assign kernel_mode_o = !debug_mode_flag_i && (!user_mode_select
                         || exception_level || error_level);
  assign boot_vector_select_o = status_ff[coproc_pkg::BOOT_VEC_BIT];

  // Debug and kernel code always reach the coprocessor
  assign cop_allowed    = debug_mode_flag_i || kernel_mode_o || sys_copro_usable;
  assign cop_unusable_o = (cop_wr_i || cop_rd_i) && !cop_allowed;
  assign wr_ok          = cop_wr_i && cop_allowed;
  assign sel_ok         = cop_sel_i == coproc_pkg::SEL_PRIMARY;
  assign wr_match       = wr_ok && sel_ok && cop_reg_i == coproc_pkg::REG_MATCH;
  assign wr_status      = wr_ok && sel_ok && cop_reg_i == coproc_pkg::REG_STATUS;
  assign wr_count       = wr_ok && sel_ok && cop_reg_i == coproc_pkg::REG_COUNT;

  // Interrupt gating; a request must be strictly above the threshold
  assign irq_enabled_o = global_irq_enable && !exception_level && !error_level
                         && !debug_mode_flag_i;
  assign irq_take_o    = irq_enabled_o && irq_req_i
                         && (irq_level_i > priority_threshold);

  // Counter link
  assign tk.wr        = wr_count;
  assign tk.wdata     = cop_wdata_i;
  assign tk.disable_c = count_disable_i;

  // Match value changes only on a software write
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      match_ff <= coproc_pkg::MATCH_RESET;
    end else if (wr_match) begin
      match_ff <= cop_wdata_i;
    end
  end

  // Edge on equality, so a count parked on the match value fires once only
  assign eq_now = tk.count == match_ff;
  assign hit    = eq_now && !eq_prev_ff;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      eq_prev_ff <= 1'b1; // Reset count and match are equal: no false hit after reset
    end else begin
      eq_prev_ff <= eq_now;
    end
  end

  // Interrupt latch: a fresh hit wins over a clearing write in the same cycle
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_ff <= 1'b0;
    end else if (hit) begin
      irq_ff <= 1'b1;
    end else if (wr_match) begin
      irq_ff <= 1'b0;
    end
  end

  assign timer_irq_o = irq_ff;

  // Status: plain bits under mask; soft reset flag clear-only, shutdown flag cleared by software and set by tlb_shutdown_set_i
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_ff <= coproc_pkg::STATUS_RESET;
    end else begin
      if (wr_status) begin
        status_ff <= (cop_wdata_i & coproc_pkg::STATUS_WMASK)
                     | (status_ff & ~coproc_pkg::STATUS_WMASK);
        status_ff[coproc_pkg::SOFT_RESET_BIT] <=
          soft_reset_flag && cop_wdata_i[coproc_pkg::SOFT_RESET_BIT];
        status_ff[coproc_pkg::SHUTDOWN_BIT] <=
          tlb_shutdown_flag && cop_wdata_i[coproc_pkg::SHUTDOWN_BIT];
      end
      if (tlb_shutdown_set_i) begin
        status_ff[coproc_pkg::SHUTDOWN_BIT] <= 1'b1;
      end
    end
  end

  // Read data is captured so it stands until the next read
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 32'h00000000;
    end else if (cop_rd_i) begin
      if (!cop_allowed || !sel_ok) begin
        rdata_ff <= 32'h00000000;
      end else begin
        unique case (cop_reg_i)
          coproc_pkg::REG_COUNT:  rdata_ff <= tk.count;
          coproc_pkg::REG_MATCH:  rdata_ff <= match_ff;
          coproc_pkg::REG_STATUS: rdata_ff <= status_ff;
          default:             rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  assign cop_rdata_o = rdata_ff;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  sequence match_write_s;
    wr_match && !hit;
  endsequence

  match_hold_a: assert property (!wr_match |=> $stable(match_ff))
    else $error("match value changed without a write");
  irq_on_hit_a: assert property (hit |=> timer_irq_o)
    else $error("timer interrupt missed a match");
  irq_hold_a: assert property (timer_irq_o && !wr_match |=> timer_irq_o)
    else $error("timer interrupt dropped without a match write");
  match_store_a: assert property (wr_match |=> match_ff == $past(cop_wdata_i))
    else $error("match write not stored");
  irq_gate_a: assert property (irq_take_o |-> global_irq_enable && !exception_level
                               && !error_level && !debug_mode_flag_i)
    else $error("interrupt taken while masked");
  threshold_gate_a: assert property (irq_take_o |-> irq_level_i > priority_threshold)
    else $error("interrupt taken at or below threshold");
  debug_mode_a: assert property (debug_mode_flag_i |-> !user_mode_o && !kernel_mode_o)
    else $error("debug mode not exclusive");
  user_mode_a: assert property (user_mode_o |-> user_mode_select && !exception_level
                                && !error_level && !debug_mode_flag_i)
    else $error("user mode without its conditions");
  kernel_mode_a: assert property (!debug_mode_flag_i |-> kernel_mode_o != user_mode_o)
    else $error("kernel and user modes not complementary");
  cop_refuse_a: assert property (cop_unusable_o && !tlb_shutdown_set_i |=> $stable(status_ff)
                                 && $stable(match_ff))
    else $error("refused access still changed state");
  kernel_cop_a: assert property (kernel_mode_o && cop_wr_i |-> !cop_unusable_o)
    else $error("kernel access refused");
  shutdown_no_set_a: assert property (!tlb_shutdown_flag && !tlb_shutdown_set_i
                                      |=> !tlb_shutdown_flag)
    else $error("shutdown flag set by software");
  soft_reset_hold_a: assert property (!soft_reset_flag |=> !soft_reset_flag)
    else $error("soft reset flag set after reset");
  irq_clear_a: assert property (match_write_s |=> !timer_irq_o)
    else $error("match write did not clear the timer interrupt");
endmodule

/* dv/irq_ctrl_model.sv */
// Interrupt controller model: turns the timer line into a pending request
`timescale 1ns/100ps
module irq_ctrl_model (
  input  wire logic       clock_i,     // Core clock
  input  wire logic       reset_n_i,   // Async reset, active low
  input  wire logic       timer_irq_i, // Timer interrupt from the core
  input  wire logic [7:0] level_i,     // Priority given to the timer source
  output logic            irq_req_o,   // Pending request back to the core
  output logic      [7:0] irq_level_o, // Priority of that request
  output logic      [7:0] events_o     // Timer assertions seen
);
  logic timer_ff;

  // Request follows the level line; the core alone decides when it drops
  assign irq_req_o   = timer_irq_i;
  assign irq_level_o = level_i;

  // Count rising edges, so a line that chatters shows up as extra events
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      timer_ff <= 1'b0;
      events_o <= 8'h00;
    end else begin
      timer_ff <= timer_irq_i;
      if (timer_irq_i && !timer_ff) begin
        events_o <= events_o + 8'h01;
      end
    end
  end
endmodule

/* dv/testbench.sv */
// Testbench for the coprocessor match timer, status register and mode decode
`timescale 1ns/100ps
module testbench;
  localparam time DRV = 5ns;
  logic        clock_i, reset_n_i, cop_wr, cop_rd, dbg, cnt_dis, tlb_set, unusable;
  logic        take, irq_en, timer, user, kern, dmode, bootv, req;
  logic [2:0]  sel;
  logic [4:0]  cop_reg;
  logic [7:0]  level, req_lvl, events;
  logic [31:0] cop_wdata, cop_rdata, rdat, c0;
  int          errors, num_checks, n;

  coproc_timer_status coproc_timer_status_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .cop_wr_i(cop_wr), .cop_rd_i(cop_rd),
    .cop_reg_i(cop_reg), .cop_sel_i(sel), .cop_wdata_i(cop_wdata),
    .cop_rdata_o(cop_rdata), .cop_unusable_o(unusable), .debug_mode_flag_i(dbg),
    .count_disable_i(cnt_dis), .tlb_shutdown_set_i(tlb_set), .irq_req_i(req),
    .irq_level_i(req_lvl), .irq_take_o(take), .irq_enabled_o(irq_en), .timer_irq_o(timer),
    .user_mode_o(user), .kernel_mode_o(kern), .debug_mode_o(dmode),
    .boot_vector_select_o(bootv));
  irq_ctrl_model irq_ctrl_model_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .timer_irq_i(timer), .level_i(level),
    .irq_req_o(req), .irq_level_o(req_lvl), .events_o(events));

  // Core clock, 100 ns period
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One move access; strobe lasts exactly one cycle, read data lands the cycle after
  task automatic access(input logic wr, input logic [4:0] rg, input logic [31:0] wd,
                        input logic unu, output logic [31:0] rd);
    @(posedge clock_i);
    #DRV;
    cop_wr = wr;
    cop_rd = !wr;
    cop_reg = rg;
    cop_wdata = wd;
    #10;
    chk({31'h0, unusable}, {31'h0, unu});
    @(posedge clock_i);
    #DRV;
    cop_wr = 1'b0;
    cop_rd = 1'b0;
    rd = cop_rdata;
  endtask
  task automatic wr(input logic [4:0] rg, input logic [31:0] d);
    access(1'b1, rg, d, 1'b0, rdat);
  endtask
  task automatic rd(input logic [4:0] rg, input logic [31:0] exp);
    access(1'b0, rg, 32'h0, 1'b0, rdat);
    chk(rdat, exp);
  endtask
  // Mode outputs as {user, kernel, debug, enabled}, masked where undefined
  task automatic mode(input logic [31:0] st, input logic d, input logic [3:0] exp,
                      input logic [3:0] m);
    wr(coproc_pkg::REG_STATUS, st);
    dbg = d;
    #10;
    chk({28'h0, {user, kern, dmode, irq_en} & m}, {28'h0, exp & m});
  endtask
  task automatic thr(input logic [31:0] st, input logic [7:0] lvl, input logic exp);
    wr(coproc_pkg::REG_STATUS, st);
    level = lvl;
    #10;
    chk({31'h0, take}, {31'h0, exp});
  endtask
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog at 20000 cycles: the whole sequence needs well under that
  initial begin
    #2000000;
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {reset_n_i, cop_wr, cop_rd, dbg, cnt_dis, tlb_set} = 6'h00;
    sel = 3'h0;
    cop_reg = 5'h00;
    cop_wdata = 32'h00000000;
    level = 8'h00;
    repeat (16) @(posedge clock_i);
    #DRV;
    reset_n_i = 1'b1;
    #10;
    chk({27'h0, user, kern, irq_en, timer, bootv}, {27'h0, 5'b01001});
    rd(coproc_pkg::REG_STATUS, coproc_pkg::STATUS_RESET);
    wr(coproc_pkg::REG_MATCH, 32'hA5A55A5A);
    rd(coproc_pkg::REG_MATCH, 32'hA5A55A5A);
    wr(coproc_pkg::REG_MATCH, 32'h5A5AA5A5);
    rd(coproc_pkg::REG_MATCH, 32'h5A5AA5A5);
    rd(5'h1F, 32'h00000000);
    // Only the primary select decodes; any other select reads zero
    sel = 3'h1;
    rd(coproc_pkg::REG_MATCH, 32'h00000000);
    sel = 3'h0;
    // Flag bits: a written one never sets them, a written zero clears them
    wr(coproc_pkg::REG_STATUS, 32'hFFFFFFFF);
    rd(coproc_pkg::REG_STATUS,
       coproc_pkg::STATUS_WMASK | (32'h1 << coproc_pkg::SOFT_RESET_BIT));
    wr(coproc_pkg::REG_STATUS, 32'h00000000);
    rd(coproc_pkg::REG_STATUS, 32'h00000000);
    @(posedge clock_i);
    #DRV;
    tlb_set = 1'b1;
    @(posedge clock_i);
    #DRV;
    tlb_set = 1'b0;
    rd(coproc_pkg::REG_STATUS, 32'h1 << coproc_pkg::SHUTDOWN_BIT);
    wr(coproc_pkg::REG_STATUS, 32'hFFFFFFFF);
    rd(coproc_pkg::REG_STATUS,
       coproc_pkg::STATUS_WMASK | (32'h1 << coproc_pkg::SHUTDOWN_BIT));
    wr(coproc_pkg::REG_STATUS, 32'h00000000);
    rd(coproc_pkg::REG_STATUS, 32'h00000000);
    // Hardware set and software clear in one cycle: the set wins
    tlb_set = 1'b1;
    wr(coproc_pkg::REG_STATUS, 32'h00000000);
    tlb_set = 1'b0;
    rd(coproc_pkg::REG_STATUS, 32'h1 << coproc_pkg::SHUTDOWN_BIT);
    wr(coproc_pkg::REG_STATUS, 32'h00000000);
    // Operating modes and the global enable
    mode(32'h00000001, 1'b0, 4'b0101, 4'hF);
    mode(32'h10000011, 1'b0, 4'b1001, 4'hF);
    mode(32'h10000013, 1'b0, 4'b0100, 4'hF);
    mode(32'h10000015, 1'b0, 4'b0100, 4'hF);
    mode(32'h10000011, 1'b1, 4'b0010, 4'h3);
    mode(32'h00000000, 1'b0, 4'b0100, 4'hF);
    // User mode without the usable bit: accesses refused and without effect
    wr(coproc_pkg::REG_STATUS, 32'h00000010);
    access(1'b0, coproc_pkg::REG_MATCH, 32'h0, 1'b1, rdat);
    chk(rdat, 32'h00000000);
    access(1'b1, coproc_pkg::REG_MATCH, 32'h12345678, 1'b1, rdat);
    dbg = 1'b1;
    rd(coproc_pkg::REG_MATCH, 32'h5A5AA5A5);
    wr(coproc_pkg::REG_STATUS, 32'h00000000);
    dbg = 1'b0;
    // Timer hit: 16 ticks at one tick per two clocks
    wr(coproc_pkg::REG_MATCH, 32'h00000110);
    wr(coproc_pkg::REG_COUNT, 32'h00000100);
    n = 0;
    while (timer !== 1'b1 && n < 60) begin
      @(posedge clock_i);
      #DRV;
      n++;
    end
    chk({31'h0, n >= 31 && n <= 35}, 32'h1);
    repeat (20) @(posedge clock_i);
    #DRV;
    chk({31'h0, timer}, 32'h1);
    chk({24'h0, events}, 32'h1);
    access(1'b0, coproc_pkg::REG_COUNT, 32'h0, 1'b0, c0);
    repeat (18) @(posedge clock_i);
    rd(coproc_pkg::REG_COUNT, c0 + 32'h0A);
    cnt_dis = 1'b1;
    access(1'b0, coproc_pkg::REG_COUNT, 32'h0, 1'b0, c0);
    repeat (18) @(posedge clock_i);
    rd(coproc_pkg::REG_COUNT, c0);
    cnt_dis = 1'b0;
    // Threshold against the pending timer request, strict greater-than
    thr(32'h00001401, 8'h05, 1'b0);
    thr(32'h00001401, 8'h06, 1'b1);
    thr(32'h00041401, 8'h85, 1'b0);
    thr(32'h00011401, 8'h46, 1'b1);
    thr(32'h00001403, 8'hFF, 1'b0);
    wr(coproc_pkg::REG_STATUS, 32'h00000000);
    // Match write clears at once; a later hit raises it again
    wr(coproc_pkg::REG_MATCH, 32'hFFFF0000);
    chk({31'h0, timer}, 32'h0);
    wr(coproc_pkg::REG_COUNT, 32'hFFFEFFF0);
    repeat (40) @(posedge clock_i);
    #DRV;
    chk({31'h0, timer}, 32'h1);
    chk({24'h0, events}, 32'h2);
    // Second reset with the interrupt up: flags return, equal reset values raise nothing
    reset_n_i = 1'b0;
    repeat (2) @(posedge clock_i);
    #DRV;
    reset_n_i = 1'b1;
    #10;
    chk({27'h0, user, kern, irq_en, timer, bootv}, {27'h0, 5'b01001});
    rd(coproc_pkg::REG_STATUS, coproc_pkg::STATUS_RESET);
    rd(coproc_pkg::REG_MATCH, coproc_pkg::MATCH_RESET);
    chk({31'h0, timer}, 32'h0);
    chk({24'h0, events}, 32'h0);
    end_of_test();
  end
endmodule
